// file: mtpd_chan_qual.sv
// Per-channel qualifier: scales a touch threshold and compares the delta count.
// Assumes the threshold and delta inputs are stable while valid results are presented.
`timescale 1ns/1ps
module mtpd_chan_qual
  import mtpd_pkg::*;
#(
  parameter int W = 8
) (
  // Threshold inputs
  input  wire logic [W-1:0] active_th,
  input  wire logic [W-1:0] standby_th,
  input  wire logic         in_standby,
  input  wire logic [1:0]   th_sel,
  // Sample inputs
  input  wire logic [W-1:0] delta,
  input  wire logic         noise,
  // Result
  output logic              qualify
);

  logic [W-1:0] base;
  logic [W+1:0] scaled;

  always_comb begin
    base = in_standby ? standby_th : active_th;
    case (th_sel)
      TH_SEL_12P5: scaled = {2'h0, base >> 3};
      TH_SEL_25:   scaled = {2'h0, base >> 2};
      TH_SEL_37P5: scaled = {2'h0, base >> 2} + {2'h0, base >> 3};
      TH_SEL_100:  scaled = {2'h0, base};
      default:     scaled = {2'h0, base};
    endcase
    qualify = noise || ({2'h0, delta} > scaled);
  end

endmodule // mtpd_chan_qual

// file: mtpd_host_model.sv
// Host model: register writes, reads and flag clears.
// Assumes the bench checks read data after rd returns.
`timescale 1ns/1ps
module mtpd_host
  import mtpd_pkg::*;
(
  // Host side
  input  wire logic    clk,
  output mtpd_reg_req_t reg_req,
  output logic          host_int_clear
);
  initial reg_req = '0;
  initial host_int_clear = 1'b0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, a, d};
    @(posedge clk) reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) reg_req <= '{1'b0, a, 8'h00};
    @(posedge clk);
  endtask
  task automatic clr;
    @(posedge clk) host_int_clear <= 1'b1;
    @(posedge clk) host_int_clear <= 1'b0;
  endtask
endmodule // mtpd_host

// file: mtpd_pkg.sv
// Package for the multiple touch pattern detector: register map, fields, resets.
// Assumes an 8-bit register port decoded by the surrounding serial interface.
package mtpd_pkg;

  localparam int         NUM_CHAN          = 3;
  localparam int         DELTA_W           = 8;
  localparam logic [7:0] ADDR_CONFIG       = 8'h2B;
  localparam logic [7:0] ADDR_CHAN_SELECT  = 8'h2D;
  localparam logic [7:0] RESET_CONFIG      = 8'h00;
  localparam logic [7:0] RESET_CHAN_SELECT = 8'h07;
  localparam int         BIT_DETECT_EN     = 7;
  localparam int         BIT_TH_SEL_HI     = 3;
  localparam int         BIT_TH_SEL_LO     = 2;
  localparam int         BIT_COMPARE_MODE  = 1;
  localparam int         BIT_ALERT_EN      = 0;
  localparam logic [7:0] CONFIG_MASK       = 8'h8F;
  localparam logic [7:0] CHAN_SELECT_MASK  = 8'h07;
  localparam logic [1:0] TH_SEL_12P5       = 2'h0;
  localparam logic [1:0] TH_SEL_25         = 2'h1;
  localparam logic [1:0] TH_SEL_37P5       = 2'h2;
  localparam logic [1:0] TH_SEL_100        = 2'h3;

  // Register port request.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mtpd_reg_req_t;

  // Per-cycle channel results from the sensing front end.
  typedef struct packed {
    logic                          valid;
    logic [NUM_CHAN-1:0]           noise;
    logic [NUM_CHAN-1:0]           standby;
    logic [NUM_CHAN*DELTA_W-1:0]   delta;
  } mtpd_sense_t;

endpackage

// file: mtpd_top.sv
// Multiple touch pattern detector: registers, criterion, blocking, flag and alert.
// Assumes one valid pulse per sensing cycle and synchronous register accesses.
// Assumes the interrupt flag register and the alert pin driver sit outside.
// What this block does
// - Detection runs only when enable bit set.
// - Threshold select picks 12.5/25/37.5/100 percent.
// - Active or standby threshold is the base.
// - Count mode: enough qualifying channels flag event.
// - Pattern mode: every selected channel must qualify.
// - Judge each sensing cycle on its own results.
// - Event blocks all touches and sets flag.
// - Blocking lasts exactly while condition holds.
// - Flag sticky; host_int_clear pulse clears it, only once blocking has ended.
// - Alert enable drives active-low alert on event.
// - Select register: one bit per channel, resets 07h.
// - Each select bit adds one to count.
`timescale 1ns/1ps
module mtpd_top
  import mtpd_pkg::*;
#(
  parameter int N = NUM_CHAN,
  parameter int W = DELTA_W
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Register port
  input  wire mtpd_reg_req_t   reg_req,
  output logic [7:0]           reg_rdata,
  // Host clear of the interrupt flag
  input  wire logic            host_int_clear,
  // Sensing front end
  input  wire mtpd_sense_t     sense,
  // Touch thresholds, active and standby
  input  wire logic [N*W-1:0]  active_th,
  input  wire logic [N*W-1:0]  standby_th,
  // Results
  output logic                 touch_block,
  output logic                 pattern_event_flag,
  output logic                 alert_n
);

  // Detector states.
  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_BLOCKED = 1'b1
  } mtpd_state_t;

  localparam int CW = $clog2(N + 1);

  // Register bank.
  logic [7:0]    config_q, config_d;
  logic [7:0]    select_q, select_d;
  logic [7:0]    rdata_q, rdata_d;

  // Detector state.
  logic          flag_q, flag_d;
  logic          alert_n_q, alert_n_d;
  logic          block_q, block_d;
  mtpd_state_t   state_q, state_d;

  // Criterion of one sensing cycle.
  logic [N-1:0]  qual;
  logic [N-1:0]  miss;
  logic [CW-1:0] need_cnt;
  logic [CW-1:0] qual_cnt;
  logic          count_match;
  logic          pattern_match;
  logic          cond;
  logic          event_now;

  // Configuration fields and strobes.
  logic          detect_en;
  logic [1:0]    th_sel;
  logic          compare_mode;
  logic          alert_en;
  logic          wr_config;
  logic          wr_select;
  logic          clear_ok;

  assign detect_en    = config_q[BIT_DETECT_EN];
  assign th_sel       = config_q[BIT_TH_SEL_HI:BIT_TH_SEL_LO];
  assign compare_mode = config_q[BIT_COMPARE_MODE];
  assign alert_en     = config_q[BIT_ALERT_EN];
  assign wr_config    = reg_req.wr && (reg_req.addr == ADDR_CONFIG);
  assign wr_select    = reg_req.wr && (reg_req.addr == ADDR_CHAN_SELECT);

  // A clear counts only once the blocking has ended.
  assign clear_ok     = host_int_clear && (state_q == ST_IDLE);

  // Per-channel qualifiers and pattern misses.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      mtpd_chan_qual #(.W(W)) mtpd_chan_qual_i (
        .active_th  (active_th[g*W +: W]),
        .standby_th (standby_th[g*W +: W]),
        .in_standby (sense.standby[g]),
        .th_sel     (th_sel),
        .delta      (sense.delta[g*W +: W]),
        .noise      (sense.noise[g]),
        .qualify    (qual[g])
      );

      assign miss[g] = select_q[g] && !qual[g];
    end
  endgenerate

  // Criterion over one sensing cycle's results only.
  always_comb begin
    need_cnt = '0;
    qual_cnt = '0;
    for (int i = 0; i < N; i++) begin
      need_cnt = need_cnt + CW'(select_q[i]);
      qual_cnt = qual_cnt + CW'(qual[i]);
    end
    count_match   = (qual_cnt >= need_cnt);
    pattern_match = !(|miss);
    cond          = compare_mode ? pattern_match : count_match;
    event_now     = sense.valid && detect_en && cond;
  end

  // Register writes and reads.
  always_comb begin
    config_d = config_q;
    select_d = select_q;
    if (wr_config) begin
      config_d = reg_req.wdata & CONFIG_MASK;
    end
    if (wr_select) begin
      select_d = reg_req.wdata & CHAN_SELECT_MASK;
    end

    case (reg_req.addr)
      ADDR_CONFIG:      rdata_d = config_d;
      ADDR_CHAN_SELECT: rdata_d = select_d;
      default:          rdata_d = 8'h00;
    endcase
  end

  // Register bank; unmapped writes leave it untouched.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_q <= RESET_CONFIG;
      select_q <= RESET_CHAN_SELECT;
      rdata_q  <= 8'h00;
    end else begin
      config_q <= config_d;
      select_q <= select_d;
      rdata_q  <= rdata_d;
    end
  end

  // Blocking state follows the criterion of each valid sensing cycle.
  always_comb begin
    state_d = state_q;
    if (!detect_en) begin
      state_d = ST_IDLE;
    end else if (sense.valid) begin
      case (state_q)
        ST_IDLE: begin
          if (event_now) begin
            state_d = ST_BLOCKED;
          end
        end
        ST_BLOCKED: begin
          if (!event_now) begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    block_d = (state_d == ST_BLOCKED);
  end

  // Registers of the blocking state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      block_q <= 1'b0;
    end else begin
      state_q <= state_d;
      block_q <= block_d;
    end
  end

  // Sticky flag and alert; a new event wins over a clear in the same cycle.
  always_comb begin
    flag_d    = flag_q;
    alert_n_d = alert_n_q;
    if (clear_ok) begin
      flag_d    = 1'b0;
      alert_n_d = 1'b1;
    end

    if (event_now) begin
      flag_d = 1'b1;
      if (alert_en) begin
        alert_n_d = 1'b0;
      end
    end
  end

  // Registers of the flag and alert.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q    <= 1'b0;
      alert_n_q <= 1'b1;
    end else begin
      flag_q    <= flag_d;
      alert_n_q <= alert_n_d;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata          = rdata_q;
  assign touch_block        = block_q;
  assign pattern_event_flag = flag_q;
  assign alert_n            = alert_n_q;

endmodule // mtpd_top

// file: mtpd_top_assertions.sv
// Checker on the pattern detector top ports.
// Assumes a bind to mtpd_top and one clock domain.
`timescale 1ns/1ps
module mtpd_chk
  import mtpd_pkg::*;
(
  // Clock, reset and host side
  input wire logic          clk,
  input wire logic          rst,
  input wire mtpd_reg_req_t reg_req,
  input wire logic [7:0]    reg_rdata,
  input wire logic          host_int_clear,
  // Sensing and results
  input wire mtpd_sense_t   sense,
  input wire logic          touch_block,
  input wire logic          pattern_event_flag,
  input wire logic          alert_n
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic       hit;
  logic       wsel;
  assign wsel = reg_req.wr && reg_req.addr == ADDR_CHAN_SELECT;
  assign hit = sense.valid && cfg_q[BIT_DETECT_EN] && (&sense.noise);
  always_comb cfg_d = (reg_req.wr && reg_req.addr == ADDR_CONFIG) ? reg_req.wdata : cfg_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_sel; wsel |=> reg_rdata == ($past(reg_req.wdata) & 8'h07); endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_off; sense.valid && !cfg_q[7] |=> !touch_block; endproperty
  a_off: assert property (p_off) else $error("block off");
  property p_hit; hit |=> touch_block && pattern_event_flag; endproperty
  a_hit: assert property (p_hit) else $error("no event");
  property p_alert; hit && cfg_q[0] |=> !alert_n; endproperty
  a_alert: assert property (p_alert) else $error("no alert");
  property p_stick; pattern_event_flag && !host_int_clear |=> pattern_event_flag; endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  property p_clr; host_int_clear && !touch_block && !sense.valid |=> !pattern_event_flag; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_hold; touch_block && !sense.valid && !reg_req.wr |=> touch_block; endproperty
  a_hold: assert property (p_hold) else $error("block lost");
  property p_cause; $rose(touch_block) |-> $past(sense.valid) && pattern_event_flag; endproperty
  a_cause: assert property (p_cause) else $error("bad block");
  c_rel: cover property (touch_block ##1 !touch_block);
  c_alert: cover property (!alert_n);
  c_clr: cover property (host_int_clear && pattern_event_flag);
endmodule // mtpd_chk

// file: tb_mtpd_top.sv
// Bench for the pattern detector: registers, modes, thresholds, flag.
// Assumes the host model owns the register port and clear.
`timescale 1ns/1ps
module tb_mtpd_top;
  import mtpd_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  mtpd_reg_req_t reg_req;
  logic          clr_p;
  logic          blk;
  logic          flag;
  logic          al_n;
  logic [7:0]    rdata;
  logic [7:0]    st;
  mtpd_sense_t   sense = '0;
  int            num_errors = 0;
  int            n_compared = 0;
  int            t = 0;
  assign st = {5'h0, blk, flag, al_n};
  always #2 clk = ~clk;
  mtpd_host h (.clk(clk), .reg_req(reg_req), .host_int_clear(clr_p));
  mtpd_top mtpd_top_i (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(rdata),
    .host_int_clear(clr_p), .sense(sense), .active_th(24'h404040),
    .standby_th(24'h202020), .touch_block(blk), .pattern_event_flag(flag), .alert_n(al_n));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    h.rd(a);
    #1 chk(rdata, e);
  endtask
  // One sensing cycle; e is block, flag, alert_n.
  task automatic ev(input logic [23:0] d, input logic [2:0] n, s, e);
    @(posedge clk) sense <= '{1'b1, n, s, d};
    @(posedge clk) sense.valid <= 1'b0;
    #1 chk(st, {5'h0, e});
  endtask
  task automatic rel(input logic a);
    ev(24'h0, 3'h0, 3'h0, {2'b01, a});
    h.clr();
    #1 chk(st, 8'h01);
  endtask
  task automatic done;
    t++;
    $display("test %0d done", t);
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] th(input int i);
    return (i == 3) ? 8'h40 : 8'(8 * (i + 1));
  endfunction
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h2B, 8'h00);
    rd(8'h2D, 8'h07);
    rd(8'h2C, 8'h00);
    ev(24'h0, 3'h7, 3'h0, 3'h1);
    h.wr(8'h2B, 8'hFF);
    h.wr(8'h2D, 8'hF9);
    rd(8'h2B, 8'h8F);
    rd(8'h2D, 8'h01);
    h.wr(8'h2C, 8'h00);
    rd(8'h2B, 8'h8F);
    done();
    for (int i = 0; i < 4; i++) begin
      h.wr(8'h2B, 8'h83 | 8'(i << 2));
      ev({16'h0, th(i)}, 3'h0, 3'h0, 3'h1);
      ev({16'h0, th(i) + 8'h01}, 3'h0, 3'h0, 3'h6);
      h.clr();
      rel(1'b0);
    end
    ev(24'h21, 3'h0, 3'h1, 3'h6);
    rel(1'b0);
    done();
    h.wr(8'h2B, 8'h8D);
    h.wr(8'h2D, 8'h05);
    ev(24'h414100, 3'h0, 3'h0, 3'h6);
    rel(1'b0);
    ev(24'h000041, 3'h0, 3'h0, 3'h1);
    ev(24'h410000, 3'h0, 3'h0, 3'h1);
    ev(24'h410000, 3'h1, 3'h0, 3'h6);
    rel(1'b0);
    ev(24'h0, 3'h7, 3'h0, 3'h6);
    rel(1'b0);
    done();
    h.wr(8'h2B, 8'h8E);
    ev(24'h414100, 3'h0, 3'h0, 3'h1);
    ev(24'h410041, 3'h0, 3'h0, 3'h7);
    rel(1'b1);
    ev(24'h410000, 3'h1, 3'h0, 3'h7);
    rel(1'b1);
    done();
    give_verdict();
  end
endmodule // tb_mtpd_top
bind mtpd_top mtpd_chk mtpd_chk_i (.clk(clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .host_int_clear(host_int_clear), .sense(sense),
  .touch_block(touch_block), .pattern_event_flag(pattern_event_flag), .alert_n(alert_n));
